// ### rtl/uilf_fmt.sv
// Character format decode and parity generation and check
`timescale 1ns/10ps
`include "uilf_map.svh"

module uilf_fmt
	import uilf_pkg::*;
(
	input  wire logic [7:0] lfc,
	input  wire logic [7:0] tx_data,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_par,
	output logic      [3:0] word_bits,
	output logic      [2:0] stop_halves,
	output logic            par_en,
	output logic            tx_par,
	output logic            rx_err
);

	logic [1:0] wl;
	logic [7:0] mask;
	logic       tx_ones;
	logic       rx_ones;
	logic       forced;
	logic       even;

	assign wl = lfc[`UILF_LFC_WL_HI:`UILF_LFC_WL_LO];
	// Values 0..3 give 5..8 data bits
	assign word_bits = `UILF_WL_BASE + {2'b00, wl};
	assign mask = {wl == 2'b11, wl >= 2'b10, wl != 2'b00, 5'h1F};
	// One stop bit, else one and a half for 5 bits, two otherwise
	assign stop_halves = !lfc[`UILF_LFC_STOP] ? `UILF_STOP_ONE :
		(wl == 2'b00) ? `UILF_STOP_ONEHALF : `UILF_STOP_TWO;

	assign par_en  = lfc[`UILF_LFC_PAR_EN];
	assign forced  = lfc[`UILF_LFC_FORCE];
	assign even    = lfc[`UILF_LFC_EVEN];
	assign tx_ones = ^(tx_data & mask);
	assign rx_ones = ^(rx_data & mask);
	// Forced parity is the inverse of the sense bit
	assign tx_par = !par_en ? 1'b0 : forced ? !even :
		(even ? tx_ones : !tx_ones);
	assign rx_err = par_en && (rx_par != (forced ? !even :
		(even ? rx_ones : !rx_ones)));

endmodule : uilf_fmt

// ### rtl/uilf_map.svh
// Register offsets, field positions, reset values and status codes
`ifndef UILF_MAP_SVH
`define UILF_MAP_SVH

`define UILF_AW          3
`define UILF_A_DIV_LO    3'h0
`define UILF_A_DIV_HI    3'h1
`define UILF_A_STATUS    3'h2
`define UILF_A_LFC       3'h3
`define UILF_A_EFC       3'h6
`define UILF_A_FIFO      3'h7

`define UILF_LFC_DLAB    7
`define UILF_LFC_BREAK   6
`define UILF_LFC_FORCE   5
`define UILF_LFC_EVEN    4
`define UILF_LFC_PAR_EN  3
`define UILF_LFC_STOP    2
`define UILF_LFC_WL_HI   1
`define UILF_LFC_WL_LO   0
`define UILF_EFC_ENH     4
`define UILF_FIFO_EN     0

`define UILF_LFC_RST     8'h00
`define UILF_EFC_RST     8'h00
`define UILF_DIV_RST     8'h00
`define UILF_FIFO_RST    1'b0
`define UILF_RD_IDLE     8'h00

`define UILF_NSRC        7
`define UILF_ID_NONE     6'h01
`define UILF_ID_LINE     6'h06
`define UILF_ID_RXDATA   6'h04
`define UILF_ID_RXTO     6'h0C
`define UILF_ID_TXE      6'h02
`define UILF_ID_MODEM    6'h00
`define UILF_ID_XOFF     6'h10
`define UILF_ID_FLOW     6'h20

`define UILF_WL_BASE     4'h5
`define UILF_STOP_ONE    3'h2
`define UILF_STOP_ONEHALF 3'h3
`define UILF_STOP_TWO    3'h4

`endif

// ### rtl/uilf_pkg.sv
// Types shared by the interrupt identification and line format logic
package uilf_pkg;

	typedef enum logic [1:0]
	{
		RPT_IDLE = 2'b00,
		RPT_HOLD = 2'b01
	} uilf_rpt_t;

	typedef enum logic [2:0]
	{
		SRC_LINE   = 3'h0,
		SRC_RXDATA = 3'h1,
		SRC_RXTO   = 3'h2,
		SRC_TXE    = 3'h3,
		SRC_MODEM  = 3'h4,
		SRC_XOFF   = 3'h5,
		SRC_FLOW   = 3'h6,
		SRC_NONE   = 3'h7
	} uilf_src_t;

endpackage : uilf_pkg

// ### rtl/uilf_top.sv
// One channel: prioritized interrupt identification and line format control
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`include "uilf_map.svh"

module uilf_top
	import uilf_pkg::*;
(
	input  wire logic                 SYS_CLK,
	input  wire logic                 RESET,
	input  wire logic [`UILF_AW-1:0]  ADDR,
	input  wire logic [7:0]           WDATA,
	input  wire logic                 WR,
	input  wire logic                 RD,
	output logic      [7:0]           RDATA,
	input  wire logic                 EVT_LINE_COND,
	input  wire logic                 EVT_RX_AVAIL,
	input  wire logic                 EVT_RX_TIMEOUT,
	input  wire logic                 EVT_TX_EMPTY,
	input  wire logic                 EVT_MODEM_CHG,
	input  wire logic                 EVT_XOFF,
	input  wire logic                 EVT_XON,
	input  wire logic                 EVT_FLOW_CHG,
	output logic                      IRQ_PENDING,
	output logic                      FIFO_ENABLE,
	output logic                      ENH_ENABLE,
	output logic      [15:0]          DIVISOR,
	input  wire logic                 TX_SERIAL,
	input  wire logic [7:0]           TX_DATA,
	input  wire logic [7:0]           RX_DATA,
	input  wire logic                 RX_PARITY,
	output logic                      TX_LINE,
	output logic                      TX_PARITY,
	output logic                      RX_PARITY_ERR,
	output logic                      PARITY_ON,
	output logic      [3:0]           WORD_BITS,
	output logic      [2:0]           STOP_HALVES
);

	localparam int NSRC = `UILF_NSRC;

	// Register state
	logic [7:0]             lfc_r;
	logic [7:0]             lfc_nxt;
	logic [7:0]             efc_r;
	logic [7:0]             efc_nxt;
	logic [7:0]             div_lo_r;
	logic [7:0]             div_lo_nxt;
	logic [7:0]             div_hi_r;
	logic [7:0]             div_hi_nxt;
	logic                   fifo_r;
	logic                   fifo_nxt;
	logic [7:0]             rdata_r;
	logic [7:0]             rdata_nxt;

	// Interrupt state
	logic [NSRC-1:0]        pend_r;
	logic [NSRC-1:0]        pend_nxt;
	logic [NSRC-1:0]        evt;
	logic [NSRC-1:0]        set_v;
	logic [NSRC-1:0]        clr_v;
	logic [NSRC-1:0]        allow_v;
	logic [NSRC-1:0]        pend_vis;
	uilf_rpt_t              rpt_r;
	uilf_rpt_t              rpt_nxt;
	uilf_src_t              cur_r;
	uilf_src_t              cur_nxt;
	uilf_src_t              top_src;
	uilf_src_t              shown;
	logic                   cur_live;

	// Decode
	logic                   dlab;
	logic                   enh;
	logic                   sel_div_lo;
	logic                   sel_div_hi;
	logic                   sel_status;
	logic                   sel_lfc;
	logic                   sel_efc;
	logic                   sel_fifo;
	logic                   rd_status;
	logic                   wr_lfc;
	logic                   wr_efc;
	logic                   wr_div_lo;
	logic                   wr_div_hi;
	logic                   wr_fifo;
	logic [5:0]             id_code;
	logic [7:0]             status_byte;
	logic [7:0]             rd_mux;

	// Line side registered outputs
	logic                   tx_line_r;
	logic                   tx_par_r;
	logic                   rx_err_r;
	logic                   par_on_r;
	logic [3:0]             wbits_r;
	logic [2:0]             stop_r;
	logic                   tx_par_w;
	logic                   rx_err_w;
	logic                   par_on_w;
	logic [3:0]             wbits_w;
	logic [2:0]             stop_w;

	// Address decode
	assign dlab       = lfc_r[`UILF_LFC_DLAB];
	assign enh        = efc_r[`UILF_EFC_ENH];
	assign sel_div_lo = (ADDR == `UILF_A_DIV_LO) && dlab;
	assign sel_div_hi = (ADDR == `UILF_A_DIV_HI) && dlab;
	assign sel_efc    = (ADDR == `UILF_A_EFC) && dlab;
	assign sel_status = (ADDR == `UILF_A_STATUS);
	assign sel_lfc    = (ADDR == `UILF_A_LFC);
	assign sel_fifo   = (ADDR == `UILF_A_FIFO);
	assign rd_status  = RD && sel_status;

	// Write enables
	assign wr_lfc    = WR && sel_lfc;
	assign wr_efc    = WR && sel_efc;
	assign wr_div_lo = WR && sel_div_lo;
	assign wr_div_hi = WR && sel_div_hi;
	assign wr_fifo   = WR && sel_fifo;

	// Register writes
	assign lfc_nxt    = wr_lfc ? WDATA : lfc_r;
	assign efc_nxt    = wr_efc ? WDATA : efc_r;
	assign div_lo_nxt = wr_div_lo ? WDATA : div_lo_r;
	assign div_hi_nxt = wr_div_hi ? WDATA : div_hi_r;
	assign fifo_nxt   = wr_fifo ? WDATA[`UILF_FIFO_EN] : fifo_r;

	// Event vector in priority order
	assign evt[SRC_LINE]   = EVT_LINE_COND;
	assign evt[SRC_RXDATA] = EVT_RX_AVAIL;
	assign evt[SRC_RXTO]   = EVT_RX_TIMEOUT;
	assign evt[SRC_TXE]    = EVT_TX_EMPTY;
	assign evt[SRC_MODEM]  = EVT_MODEM_CHG;
	assign evt[SRC_XOFF]   = EVT_XOFF;
	assign evt[SRC_FLOW]   = EVT_FLOW_CHG;

	// Flags that may be shown; enhanced codes need the enable
	assign pend_vis = pend_r & allow_v;

	// Highest pending source, lowest index wins
	assign top_src =
		pend_vis[SRC_LINE]   ? SRC_LINE   :
		pend_vis[SRC_RXDATA] ? SRC_RXDATA :
		pend_vis[SRC_RXTO]   ? SRC_RXTO   :
		pend_vis[SRC_TXE]    ? SRC_TXE    :
		pend_vis[SRC_MODEM]  ? SRC_MODEM  :
		pend_vis[SRC_XOFF]   ? SRC_XOFF   :
		pend_vis[SRC_FLOW]   ? SRC_FLOW   : SRC_NONE;

	// Held source keeps its place until read or until its flag clears
	assign cur_live = (cur_r != SRC_NONE) && pend_vis[cur_r];
	assign shown    = (rpt_r == RPT_HOLD && cur_live) ? cur_r : top_src;

	// Per source sticky flag; set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi = gi + 1)
		begin : g_src
			if (gi == SRC_XOFF || gi == SRC_FLOW)
			begin : g_enh
				assign allow_v[gi] = enh;
			end
			else
			begin : g_std
				assign allow_v[gi] = 1'b1;
			end
			assign set_v[gi] = evt[gi] && allow_v[gi];
			if (gi == SRC_XOFF)
			begin : g_xoff
				assign clr_v[gi] = EVT_XON || !enh;
			end
			else
			begin : g_rd
				assign clr_v[gi] = (rd_status && (shown == gi)) || !allow_v[gi];
			end
			assign pend_nxt[gi] = set_v[gi] || (pend_r[gi] && !clr_v[gi]);
		end
	endgenerate

	// Report hold machine
	always_comb
	begin
		rpt_nxt = rpt_r;
		cur_nxt = cur_r;
		unique case (rpt_r)
			RPT_IDLE:
			begin
				if (!rd_status && top_src != SRC_NONE)
				begin
					rpt_nxt = RPT_HOLD;
					cur_nxt = top_src;
				end
			end
			RPT_HOLD:
			begin
				if (rd_status || !cur_live)
				begin
					rpt_nxt = RPT_IDLE;
					cur_nxt = SRC_NONE;
				end
			end
			default:
			begin
				rpt_nxt = RPT_IDLE;
				cur_nxt = SRC_NONE;
			end
		endcase
	end

	// Identification code of the shown source
	assign id_code =
		(shown == SRC_LINE)   ? `UILF_ID_LINE   :
		(shown == SRC_RXDATA) ? `UILF_ID_RXDATA :
		(shown == SRC_RXTO)   ? `UILF_ID_RXTO   :
		(shown == SRC_TXE)    ? `UILF_ID_TXE    :
		(shown == SRC_MODEM)  ? `UILF_ID_MODEM  :
		(shown == SRC_XOFF)   ? `UILF_ID_XOFF   :
		(shown == SRC_FLOW)   ? `UILF_ID_FLOW   : `UILF_ID_NONE;

	assign status_byte = {fifo_r, fifo_r, id_code};

	// Read data select; unmapped reads give zero
	assign rd_mux =
		sel_status ? status_byte :
		sel_lfc    ? lfc_r :
		sel_div_lo ? div_lo_r :
		sel_div_hi ? div_hi_r :
		sel_efc    ? efc_r :
		sel_fifo   ? {7'h00, fifo_r} : `UILF_RD_IDLE;

	assign rdata_nxt = RD ? rd_mux : `UILF_RD_IDLE;

	// Format decode and parity
	uilf_fmt u_fmt
	(
		.lfc         (lfc_r),
		.tx_data     (TX_DATA),
		.rx_data     (RX_DATA),
		.rx_par      (RX_PARITY),
		.word_bits   (wbits_w),
		.stop_halves (stop_w),
		.par_en      (par_on_w),
		.tx_par      (tx_par_w),
		.rx_err      (rx_err_w)
	);

	// Control registers
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			lfc_r    <= `UILF_LFC_RST;
			efc_r    <= `UILF_EFC_RST;
			div_lo_r <= `UILF_DIV_RST;
			div_hi_r <= `UILF_DIV_RST;
			fifo_r   <= `UILF_FIFO_RST;
			rdata_r  <= `UILF_RD_IDLE;
		end
		else
		begin
			lfc_r    <= lfc_nxt;
			efc_r    <= efc_nxt;
			div_lo_r <= div_lo_nxt;
			div_hi_r <= div_hi_nxt;
			fifo_r   <= fifo_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// Interrupt registers
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			pend_r <= '0;
			rpt_r  <= RPT_IDLE;
			cur_r  <= SRC_NONE;
		end
		else
		begin
			pend_r <= pend_nxt;
			rpt_r  <= rpt_nxt;
			cur_r  <= cur_nxt;
		end
	end

	// Line side outputs
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			tx_line_r <= 1'b1;
			tx_par_r  <= 1'b0;
			rx_err_r  <= 1'b0;
			par_on_r  <= 1'b0;
			wbits_r   <= `UILF_WL_BASE;
			stop_r    <= `UILF_STOP_ONE;
		end
		else
		begin
			tx_line_r <= TX_SERIAL && !lfc_r[`UILF_LFC_BREAK];
			tx_par_r  <= tx_par_w;
			rx_err_r  <= rx_err_w;
			par_on_r  <= par_on_w;
			wbits_r   <= wbits_w;
			stop_r    <= stop_w;
		end
	end

	// Outputs
	assign RDATA         = rdata_r;
	assign IRQ_PENDING   = (shown != SRC_NONE);
	assign FIFO_ENABLE   = fifo_r;
	assign ENH_ENABLE    = enh;
	assign DIVISOR       = {div_hi_r, div_lo_r};
	assign TX_LINE       = tx_line_r;
	assign TX_PARITY     = tx_par_r;
	assign RX_PARITY_ERR = rx_err_r;
	assign PARITY_ON     = par_on_r;
	assign WORD_BITS     = wbits_r;
	assign STOP_HALVES   = stop_r;

endmodule : uilf_top

// ### tb/tb_top.sv
// Self-checking bench for one channel's status and format logic
`timescale 1ns/10ps
module tb_top
	import uilf_pkg::*;
;
	logic        clk;
	logic        rst;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [7:0]  ev;
	logic        irq;
	logic        fifo_on;
	logic        enh_on;
	logic [15:0] div;
	logic        txs;
	logic [7:0]  txd;
	logic [7:0]  rxd;
	logic        rxp;
	logic        tx_line;
	logic        tx_par;
	logic        perr;
	logic        par_on;
	logic [3:0]  wb;
	logic [2:0]  sh;
	logic [7:0]  d;
	int          n_errors;
	int          n_checks;
	int          cyc = 0;
	uilf_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	uilf_top u_dut (.SYS_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .EVT_LINE_COND(ev[0]), .EVT_RX_AVAIL(ev[1]), .EVT_RX_TIMEOUT(ev[2]),
		.EVT_TX_EMPTY(ev[3]), .EVT_MODEM_CHG(ev[4]), .EVT_XOFF(ev[5]), .EVT_XON(ev[6]),
		.EVT_FLOW_CHG(ev[7]), .IRQ_PENDING(irq), .FIFO_ENABLE(fifo_on), .ENH_ENABLE(enh_on),
		.DIVISOR(div), .TX_SERIAL(txs), .TX_DATA(txd), .RX_DATA(rxd), .RX_PARITY(rxp),
		.TX_LINE(tx_line), .TX_PARITY(tx_par), .RX_PARITY_ERR(perr), .PARITY_ON(par_on),
		.WORD_BITS(wb), .STOP_HALVES(sh));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic test_done;
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic pulse(input logic [7:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
	endtask : pulse
	task automatic st(input logic [2:0] a, input logic [7:0] e);
		u_host.rd_reg(a, d);
		chk("read", {8'h00, e}, {8'h00, d});
	endtask : st
	task automatic settle;
		@(posedge clk);
		#1;
	endtask : settle
	task automatic t_reset;
		settle();
		chk("bits", 16'h0005, {12'h000, wb});
		chk("stop", 16'h0002, {13'h0000, sh});
		chk("line", 16'h0001, {15'h0000, tx_line});
		chk("pending", 16'h0000, {15'h0000, irq});
		chk("fifo", 16'h0000, {15'h0000, fifo_on});
		st(3'h2, 8'h01);
		st(3'h3, 8'h00);
	endtask : t_reset
	task automatic t_prio;
		logic [7:0] e [6];
		e = '{8'h06, 8'h04, 8'h0C, 8'h02, 8'h00, 8'h01};
		pulse(8'h1F);
		for (int i = 0; i < 6; i++)
			st(3'h2, e[i]);
		chk("pending", 16'h0000, {15'h0000, irq});
	endtask : t_prio
	task automatic t_hold;
		pulse(8'h08);
		pulse(8'h01);
		settle();
		chk("pending", 16'h0001, {15'h0000, irq});
		st(3'h2, 8'h02);
		fork
			st(3'h2, 8'h06);
			pulse(8'h08);
		join
		st(3'h2, 8'h02);
		st(3'h2, 8'h01);
		pulse(8'h08);
		fork
			st(3'h2, 8'h02);
			pulse(8'h08);
		join
		st(3'h2, 8'h02);
		st(3'h2, 8'h01);
	endtask : t_hold
	task automatic t_enh;
		u_host.wr_reg(3'h3, 8'h80);
		u_host.wr_reg(3'h6, 8'h10);
		settle();
		chk("enh", 16'h0001, {15'h0000, enh_on});
		st(3'h6, 8'h10);
		u_host.wr_reg(3'h0, 8'h5A);
		u_host.wr_reg(3'h1, 8'hC3);
		u_host.wr_reg(3'h3, 8'h00);
		u_host.wr_reg(3'h0, 8'hFF);
		settle();
		chk("divisor", 16'hC35A, div);
		st(3'h6, 8'h00);
		st(3'h4, 8'h00);
		u_host.wr_reg(3'h7, 8'h01);
		settle();
		chk("fifo", 16'h0001, {15'h0000, fifo_on});
		pulse(8'h20);
		st(3'h2, 8'hD0);
		st(3'h2, 8'hD0);
		pulse(8'h40);
		pulse(8'h80);
		st(3'h2, 8'hE0);
		st(3'h2, 8'hC1);
		pulse(8'h20);
		u_host.wr_reg(3'h3, 8'h80);
		u_host.wr_reg(3'h6, 8'h00);
		u_host.wr_reg(3'h3, 8'h00);
		chk("enh", 16'h0000, {15'h0000, enh_on});
		st(3'h2, 8'hC1);
		pulse(8'hA0);
		st(3'h2, 8'hC1);
		u_host.wr_reg(3'h7, 8'h00);
	endtask : t_enh
	task automatic t_fmt;
		logic [7:0] m [6];
		logic       p [6];
		m = '{8'h03, 8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h08};
		p = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 4; i++)
		begin
			u_host.wr_reg(3'h3, 8'h04 | 8'(i));
			settle();
			chk("bits", 16'(5 + i), {12'h000, wb});
			chk("stop", (i == 0) ? 16'h0003 : 16'h0004, {13'h0000, sh});
		end
		@(posedge clk);
		txd <= 8'hE7;
		rxd <= 8'hE7;
		for (int i = 0; i < 6; i++)
		begin
			u_host.wr_reg(3'h3, m[i]);
			rxp <= p[i];
			settle();
			chk("parity", {15'h0000, p[i]}, {15'h0000, tx_par});
			chk("parity_on", {15'h0000, m[i][3]}, {15'h0000, par_on});
			chk("rx_err", 16'h0000, {15'h0000, perr});
		end
		@(posedge clk);
		rxp <= 1'b1;
		settle();
		chk("rx_err", 16'h0001, {15'h0000, perr});
		u_host.wr_reg(3'h3, 8'h40);
		settle();
		chk("line", 16'h0000, {15'h0000, tx_line});
		u_host.wr_reg(3'h3, 8'h00);
		settle();
		chk("line", 16'h0001, {15'h0000, tx_line});
		@(posedge clk);
		txs <= 1'b0;
		settle();
		chk("line", 16'h0000, {15'h0000, tx_line});
	endtask : t_fmt
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			test_done();
		end
	end
	initial
	begin
		rst = 1'b1;
		ev = 8'h00;
		txs = 1'b1;
		txd = 8'h00;
		rxd = 8'h00;
		rxp = 1'b0;
		n_errors = 0;
		n_checks = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_prio();
		t_hold();
		t_enh();
		t_fmt();
		test_done();
	end
endmodule : tb_top

// ### tb/uilf_assertions.sv
// Port-level checker for status and line format behaviour
`timescale 1ns/10ps
module uilf_chk
(
	input wire logic       SYS_CLK,
	input wire logic       RESET,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       IRQ_PENDING,
	input wire logic       FIFO_ENABLE,
	input wire logic       ENH_ENABLE,
	input wire logic       TX_LINE,
	input wire logic       TX_PARITY,
	input wire logic       PARITY_ON,
	input wire logic [3:0] WORD_BITS,
	input wire logic [2:0] STOP_HALVES
);
	logic [7:0] lfc_r;
	wire logic  st_rd;
	wire logic  gated_rd;
	assign st_rd = RD && ADDR == 3'h2;
	assign gated_rd = RD && !lfc_r[7] && (ADDR == 3'h0 || ADDR == 3'h1 || ADDR == 3'h6);
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			lfc_r <= 8'h00;
		else if (WR && ADDR == 3'h3)
			lfc_r <= WDATA;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	AST_IDLE_BIT: assert property (st_rd |=> RDATA[0] == !$past(IRQ_PENDING))
		else $error("status bit 0 wrong");
	AST_FIFO_BITS: assert property (st_rd |=> RDATA[7:6] == {2{$past(FIFO_ENABLE)}})
		else $error("status bits 7:6 wrong");
	AST_ENH_OFF: assert property (!ENH_ENABLE [*3] ##0 st_rd |=> RDATA[5:4] == 2'b00)
		else $error("enhanced codes while disabled");
	AST_GATED: assert property (gated_rd |=> RDATA == 8'h00)
		else $error("gated register readable");
	AST_BREAK: assert property (lfc_r[6] |=> !TX_LINE)
		else $error("break not driven");
	AST_FORCED: assert property (lfc_r[5] && lfc_r[3] |=> TX_PARITY == !$past(lfc_r[4]))
		else $error("forced parity wrong");
	AST_NO_PAR: assert property (!lfc_r[3] |=> !TX_PARITY && !PARITY_ON)
		else $error("parity while off");
	AST_STOP_ONE: assert property (!lfc_r[2] |=> STOP_HALVES == 3'h2)
		else $error("stop length wrong");
	AST_STOP_LONG: assert property (lfc_r[2] |=>
		STOP_HALVES == (($past(lfc_r[1:0]) == 2'b00) ? 3'h3 : 3'h4))
		else $error("long stop wrong");
	AST_WORD: assert property (WR && ADDR == 3'h3 |->
		##2 WORD_BITS == 4'h5 + {2'b00, $past(WDATA[1:0], 2)})
		else $error("word length wrong");
endmodule : uilf_chk
bind uilf_top uilf_chk u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_PENDING(IRQ_PENDING), .FIFO_ENABLE(FIFO_ENABLE),
	.ENH_ENABLE(ENH_ENABLE), .TX_LINE(TX_LINE), .TX_PARITY(TX_PARITY),
	.PARITY_ON(PARITY_ON), .WORD_BITS(WORD_BITS), .STOP_HALVES(STOP_HALVES));

// ### tb/uilf_host.sv
// Host register bus master model
`timescale 1ns/10ps
module uilf_host
(
	input  wire logic       clk,
	output logic      [2:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	initial
	begin
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg
endmodule : uilf_host
